// ### logic/orc_pkg.sv
// constants and carrier types of the output frequency ramp control
package orc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_CS = 10_000 / TICK_US;

  // ==========================================================
  // setting limits and codes (time 0.01 s, freq 0.01 Hz, 0.1 A)
  localparam logic [15:0] MIN_TIME_LIMIT = 16'h0003;
  localparam logic [15:0] MIN_TIME_USED  = 16'h0004;
  localparam logic [15:0] CODE_OFF       = 16'h270F;
  localparam logic [15:0] MAX_TIME       = 16'h8CA0;
  localparam logic [15:0] START_FREQ_MAX = 16'h1770;
  localparam logic [15:0] HOLD_MAX       = 16'h03E8;
  localparam logic [15:0] LIMIT_MAX      = 16'h00C8;
  localparam logic [15:0] DEF_LIMIT      = 16'h0096;
  localparam logic [15:0] CURRENT_MAX    = 16'h1388;
  localparam logic [15:0] FREQ_MAX       = 16'h9C40;
  localparam logic [15:0] CMD_FULL       = 16'h2710;
  localparam logic [15:0] PCT_FULL       = 16'h0064;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_ACCEL      = 8'h00;
  localparam logic [7:0] OFS_DECEL      = 8'h04;
  localparam logic [7:0] OFS_ACCEL2     = 8'h08;
  localparam logic [7:0] OFS_DECEL2     = 8'h0C;
  localparam logic [7:0] OFS_RAMP_REF   = 8'h10;
  localparam logic [7:0] OFS_START_FREQ = 8'h14;
  localparam logic [7:0] OFS_HOLD_TIME  = 8'h18;
  localparam logic [7:0] OFS_PATTERN    = 8'h1C;
  localparam logic [7:0] OFS_AUTO       = 8'h20;
  localparam logic [7:0] OFS_DIR_SEL    = 8'h24;
  localparam logic [7:0] OFS_REF_CUR    = 8'h28;
  localparam logic [7:0] OFS_ACC_LIM    = 8'h2C;
  localparam logic [7:0] OFS_DEC_LIM    = 8'h30;
  localparam logic [7:0] OFS_STALL      = 8'h34;
  localparam logic [7:0] OFS_BASE       = 8'h38;
  localparam logic [7:0] OFS_MIN_FREQ   = 8'h3C;
  localparam logic [7:0] OFS_GAIN       = 8'h40;
  localparam logic [7:0] OFS_STATUS     = 8'h44;
  localparam logic [7:0] OFS_LIMITS     = 8'h48;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_ACCEL      = 16'h01F4;
  localparam logic [15:0] RST_DECEL      = 16'h01F4;
  localparam logic [15:0] RST_ACCEL2     = 16'h01F4;
  localparam logic [15:0] RST_DECEL2     = 16'h270F;
  localparam logic [15:0] RST_RAMP_REF   = 16'h1770;
  localparam logic [15:0] RST_START_FREQ = 16'h0032;
  localparam logic [15:0] RST_HOLD_TIME  = 16'h270F;
  localparam logic [15:0] RST_AUTO_CODE  = 16'h0000;
  localparam logic [15:0] RST_REF_CUR    = 16'h270F;
  localparam logic [15:0] RST_LIMIT      = 16'h270F;
  localparam logic [15:0] RST_STALL      = 16'h0096;
  localparam logic [15:0] RST_BASE       = 16'h1770;
  localparam logic [15:0] RST_MIN_FREQ   = 16'h0000;
  localparam logic [15:0] RST_GAIN       = 16'h1770;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    PAT_LINEAR = 2'h0,
    PAT_S_A    = 2'h1,
    PAT_S_B    = 2'h2
  } orc_pattern_type;

  localparam logic [15:0] AUTO_NORMAL      = 16'h0000;
  localparam logic [15:0] AUTO_SHORT       = 16'h0001;
  localparam logic [15:0] AUTO_BRAKE_SEQ1  = 16'h0007;
  localparam logic [15:0] AUTO_BRAKE_SEQ2  = 16'h0008;
  localparam logic [15:0] AUTO_SHORT_BRAKE = 16'h000B;

  typedef enum logic [1:0] {
    SHORT_BOTH = 2'h0,
    SHORT_ACC  = 2'h1,
    SHORT_DEC  = 2'h2
  } orc_dir_sel_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_HOLD  = 3'h1,
    ST_RUN   = 3'h3,
    ST_DECEL = 3'h2,
    ST_REV   = 3'h6
  } orc_state_type;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [15:0]     accel;
    logic [15:0]     decel;
    logic [15:0]     accel2;
    logic [15:0]     decel2;
    logic [15:0]     ramp_ref;
    logic [15:0]     start_freq;
    logic [15:0]     hold_time;
    orc_pattern_type pattern;
    logic [15:0]     auto_code;
    orc_dir_sel_type dir_sel;
    logic [15:0]     ref_cur;
    logic [15:0]     acc_lim;
    logic [15:0]     dec_lim;
    logic [15:0]     stall;
    logic [15:0]     base;
    logic [15:0]     min_freq;
    logic [15:0]     gain;
  } orc_cfg_type;

  typedef struct packed {
    logic          shortest;
    logic          stall;
    logic          holding;
    logic          running;
    orc_state_type state;
    logic          dir;
    logic [15:0]   freq;
  } orc_stat_type;

endpackage : orc_pkg

// ### logic/orc_ramp_control.sv
// output frequency ramp control with apb settings registers
// Overview of operation
// - ramp times at or below 0.03 s are replaced by 0.04 s.
// - writing the ramp reference frequency never alters the gain setting.
// - starting frequency 0 to 60 Hz, default 0.5 Hz, output starts there.
// - no start while the frequency command is below the starting frequency, unless the preset case below applies.
// - a start hold of 0 to 10 s keeps the start frequency; 9999 disables.
// - start released during the hold ends it and decelerates at once.
// - reversal applies the starting frequency but skips the hold.
// - start frequency at or below minimum runs at preset without command.
// - pattern code 0 linear, 1 s-curve a, 2 s-curve b, default linear.
// - linear mode uses a constant slope, set separately by the acceleration and the deceleration time.
// - s-curve a bends at base frequency, slope falling as frequency rises above it.
// - s-curve a ramp time is the time to reach base frequency.
// - s-curve b shapes every change from present to new target.
// - auto code 0 normal, 1 and 11 shortest, 7 and 8 brake sequence; here 7 and 8 are only stored and run as normal.
// - direction select 0 both, 1 acceleration only, 2 deceleration only.
// - shortest mode rate taken at ramp start, stored times untouched.
// - shortest ramp limit defaults 150 percent; stall level at constant.
// - reference current 0 to 500 A; 9999 selects rated current.
// - limits 0 to 200 percent; 9999 selects 150 percent.
// - second function input selects the second ramp times.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module orc_ramp_control
  import orc_pkg::*;
#(
  parameter int          TICK_LEN      = TICK_CYCLES,
  parameter logic [15:0] RATED_CURRENT = 16'h0050
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        start_cmd,
  input  wire logic        reverse_cmd,
  input  wire logic        second_function_select,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] motor_current,
  output logic      [15:0] freq_out,
  output logic             dir_out,
  output logic             running,
  output logic             holding,
  output logic             stall_active
);

  // ==========================================================
  // elaboration check
  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end

  // ==========================================================
  // helpers
  function automatic logic [47:0] orc_div(input logic [47:0] n,
                                          input logic [47:0] d);
    orc_div = (d == 48'h0) ? 48'hFFFF_FFFF_FFFF : n / d;
  endfunction : orc_div

  function automatic logic [15:0] orc_time(input logic [15:0] t);
    orc_time = (t <= MIN_TIME_LIMIT) ? MIN_TIME_USED : t;
  endfunction : orc_time

  function automatic logic [15:0] orc_pct(input logic [15:0] p);
    orc_pct = (p == CODE_OFF) ? DEF_LIMIT : p;
  endfunction : orc_pct

  function automatic logic [15:0] orc_abs(input logic [15:0] a,
                                          input logic [15:0] b);
    orc_abs = (a > b) ? a - b : b - a;
  endfunction : orc_abs

  // ==========================================================
  // state
  orc_cfg_type   cfg_q;
  orc_state_type state_q, state_d;
  logic [23:0]   acc_q, acc_d;
  logic [23:0]   lin_q;
  logic [15:0]   origin_q;
  logic [1:0]    phase_q;
  logic          dir_q, dir_d;
  logic [15:0]   hold_q, hold_d;
  logic [31:0]   tick_q;
  logic [31:0]   prdata_q;
  logic [31:0]   rdata;
  logic          hit;
  logic          wr_ok;

  // ==========================================================
  // apb slave
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_write  = apb_access & pwrite & ce & hit & wr_ok;

  assign pready  = ce;
  assign pslverr = apb_access & (~hit | (pwrite & ~wr_ok));
  assign prdata  = prdata_q;

  wire [15:0] wd = pwdata[15:0];
  wire        hi_zero = (pwdata[31:16] == 16'h0000);
  wire        wd_time = hi_zero & (wd <= MAX_TIME);
  wire        wd_lim  = hi_zero & ((wd <= LIMIT_MAX) | (wd == CODE_OFF));

  orc_stat_type stat;
  logic [15:0]  ramp_limit, const_limit;

  always_comb begin
    hit   = 1'b1;
    wr_ok = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == OFS_ACCEL) begin
      rdata = {16'h0000, cfg_q.accel};
      wr_ok = wd_time;
    end else if (paddr == OFS_DECEL) begin
      rdata = {16'h0000, cfg_q.decel};
      wr_ok = wd_time;
    end else if (paddr == OFS_ACCEL2) begin
      rdata = {16'h0000, cfg_q.accel2};
      wr_ok = wd_time;
    end else if (paddr == OFS_DECEL2) begin
      rdata = {16'h0000, cfg_q.decel2};
      wr_ok = wd_time | (hi_zero & (wd == CODE_OFF));
    end else if (paddr == OFS_RAMP_REF) begin
      rdata = {16'h0000, cfg_q.ramp_ref};
      wr_ok = hi_zero & (wd <= FREQ_MAX) & (wd != 16'h0000);
    end else if (paddr == OFS_START_FREQ) begin
      rdata = {16'h0000, cfg_q.start_freq};
      wr_ok = hi_zero & (wd <= START_FREQ_MAX);
    end else if (paddr == OFS_HOLD_TIME) begin
      rdata = {16'h0000, cfg_q.hold_time};
      wr_ok = hi_zero & ((wd <= HOLD_MAX) | (wd == CODE_OFF));
    end else if (paddr == OFS_PATTERN) begin
      rdata = {30'h0000_0000, cfg_q.pattern};
      wr_ok = (pwdata <= 32'h0000_0002);
    end else if (paddr == OFS_AUTO) begin
      rdata = {16'h0000, cfg_q.auto_code};
      wr_ok = hi_zero & ((wd == AUTO_NORMAL) | (wd == AUTO_SHORT) |
              (wd == AUTO_SHORT_BRAKE) | (wd == AUTO_BRAKE_SEQ1) |
              (wd == AUTO_BRAKE_SEQ2));
    end else if (paddr == OFS_DIR_SEL) begin
      rdata = {30'h0000_0000, cfg_q.dir_sel};
      wr_ok = (pwdata <= 32'h0000_0002);
    end else if (paddr == OFS_REF_CUR) begin
      rdata = {16'h0000, cfg_q.ref_cur};
      wr_ok = hi_zero & ((wd <= CURRENT_MAX) | (wd == CODE_OFF));
    end else if (paddr == OFS_ACC_LIM) begin
      rdata = {16'h0000, cfg_q.acc_lim};
      wr_ok = wd_lim;
    end else if (paddr == OFS_DEC_LIM) begin
      rdata = {16'h0000, cfg_q.dec_lim};
      wr_ok = wd_lim;
    end else if (paddr == OFS_STALL) begin
      rdata = {16'h0000, cfg_q.stall};
      wr_ok = hi_zero & (wd <= LIMIT_MAX);
    end else if (paddr == OFS_BASE) begin
      rdata = {16'h0000, cfg_q.base};
      wr_ok = hi_zero & (wd <= FREQ_MAX) & (wd != 16'h0000);
    end else if (paddr == OFS_MIN_FREQ) begin
      rdata = {16'h0000, cfg_q.min_freq};
      wr_ok = hi_zero & (wd <= FREQ_MAX);
    end else if (paddr == OFS_GAIN) begin
      rdata = {16'h0000, cfg_q.gain};
      wr_ok = hi_zero & (wd <= FREQ_MAX);
    end else if (paddr == OFS_STATUS) begin
      rdata = {8'h00, stat};
      wr_ok = 1'b0;
    end else if (paddr == OFS_LIMITS) begin
      rdata = {const_limit, ramp_limit};
      wr_ok = 1'b0;
    end else begin
      hit   = 1'b0;
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && apb_setup) begin
      prdata_q <= rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{RST_ACCEL, RST_DECEL, RST_ACCEL2, RST_DECEL2,
                 RST_RAMP_REF, RST_START_FREQ, RST_HOLD_TIME, PAT_LINEAR,
                 RST_AUTO_CODE, SHORT_BOTH, RST_REF_CUR, RST_LIMIT,
                 RST_LIMIT, RST_STALL, RST_BASE, RST_MIN_FREQ, RST_GAIN};
    end else if (apb_write) begin
      if (paddr == OFS_ACCEL) cfg_q.accel <= wd;
      else if (paddr == OFS_DECEL) cfg_q.decel <= wd;
      else if (paddr == OFS_ACCEL2) cfg_q.accel2 <= wd;
      else if (paddr == OFS_DECEL2) cfg_q.decel2 <= wd;
      else if (paddr == OFS_RAMP_REF) cfg_q.ramp_ref <= wd;
      else if (paddr == OFS_START_FREQ) cfg_q.start_freq <= wd;
      else if (paddr == OFS_HOLD_TIME) cfg_q.hold_time <= wd;
      else if (paddr == OFS_PATTERN) cfg_q.pattern <= orc_pattern_type'(wd[1:0]);
      else if (paddr == OFS_AUTO) cfg_q.auto_code <= wd;
      else if (paddr == OFS_DIR_SEL) cfg_q.dir_sel <= orc_dir_sel_type'(wd[1:0]);
      else if (paddr == OFS_REF_CUR) cfg_q.ref_cur <= wd;
      else if (paddr == OFS_ACC_LIM) cfg_q.acc_lim <= wd;
      else if (paddr == OFS_DEC_LIM) cfg_q.dec_lim <= wd;
      else if (paddr == OFS_STALL) cfg_q.stall <= wd;
      else if (paddr == OFS_BASE) cfg_q.base <= wd;
      else if (paddr == OFS_MIN_FREQ) cfg_q.min_freq <= wd;
      else if (paddr == OFS_GAIN) cfg_q.gain <= wd;
    end
  end

  // ==========================================================
  // control tick
  wire tick = (tick_q == 32'h0000_0000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 32'h0000_0000;
    end else if (ce) begin
      tick_q <= tick ? 32'(TICK_LEN - 1) : tick_q - 32'h0000_0001;
    end
  end

  // ==========================================================
  // command and target
  wire [15:0] out_f    = acc_q[23:8];
  wire [47:0] cmd_w    = orc_div(48'(freq_cmd) * 48'(cfg_q.gain),
                                 48'(CMD_FULL));
  wire [15:0] cmd_f    = cmd_w[15:0];
  wire        preset   = cfg_q.start_freq <= cfg_q.min_freq;
  wire        start_ok = preset | (cmd_f >= cfg_q.start_freq);
  wire [15:0] run_f    = (cmd_f < cfg_q.min_freq) ? cfg_q.min_freq : cmd_f;
  wire [23:0] start_fp = {cfg_q.start_freq, 8'h00};
  wire [23:0] tgt_fp   = (state_q == ST_RUN) ? {run_f, 8'h00} : 24'h0;
  wire        accel    = tgt_fp > acc_q;
  wire [1:0]  phase_d  = (tgt_fp == acc_q) ? 2'h0 : (accel ? 2'h1 : 2'h2);

  // ==========================================================
  // slope
  wire [15:0] dec2   = (cfg_q.decel2 == CODE_OFF) ? cfg_q.accel2
                                                 : cfg_q.decel2;
  wire [15:0] acc_t  = second_function_select ? cfg_q.accel2
                                              : cfg_q.accel;
  wire [15:0] dec_t  = second_function_select ? dec2 : cfg_q.decel;
  wire [15:0] ramp_t = orc_time(accel ? acc_t : dec_t);
  wire [15:0] ref_f  = (cfg_q.pattern == PAT_S_A) ? cfg_q.base
                                                  : cfg_q.ramp_ref;
  wire [47:0] lin_div = orc_div({8'h00, ref_f, 24'h0},
                        48'(ramp_t) * 48'(TICKS_PER_CS));
  wire [23:0] lin_now = lin_div[39:16];

  wire [47:0] lin_w  = {24'h0, lin_q};
  wire [47:0] sa_raw = orc_div(lin_w * 48'(cfg_q.base) * 48'h9,
                               48'(out_f) * 48'h8);
  wire [23:0] step_a = (out_f >= cfg_q.base) ? sa_raw[23:0] : lin_q;

  wire [15:0] span   = orc_abs(tgt_fp[23:8], origin_q);
  wire [15:0] dist_p = orc_abs(out_f, origin_q);
  wire [15:0] dist_r = orc_abs(tgt_fp[23:8], out_f);
  wire [15:0] dist_m = (dist_p < dist_r) ? dist_p : dist_r;
  wire [47:0] sb_raw = orc_div(lin_w * 48'(dist_m) * 48'h4, 48'(span));
  wire [23:0] sb_min = (lin_q[23:3] == 21'h0) ? 24'h1 : {3'h0, lin_q[23:3]};
  wire [23:0] step_b = (span == 16'h0) ? lin_q :
                       (sb_raw[23:0] < sb_min) ? sb_min : sb_raw[23:0];

  // ==========================================================
  // shortest mode and stall limits
  wire short_code = (cfg_q.auto_code == AUTO_SHORT) |
                    (cfg_q.auto_code == AUTO_SHORT_BRAKE);
  wire short_dir  = (cfg_q.dir_sel == SHORT_BOTH) |
                    ((cfg_q.dir_sel == SHORT_ACC) & accel) |
                    ((cfg_q.dir_sel == SHORT_DEC) & ~accel);
  wire ramping    = (phase_d != 2'h0) && (state_q != ST_IDLE) &&
                    (state_q != ST_HOLD);
  wire shortest   = short_code & short_dir & ramping;
  wire [15:0] ref_i = (cfg_q.ref_cur == CODE_OFF) ? RATED_CURRENT
                                                  : cfg_q.ref_cur;
  wire [15:0] lim_p = orc_pct(accel ? cfg_q.acc_lim
                                    : cfg_q.dec_lim);

  wire [47:0] rlim_w = orc_div(48'(ref_i) * 48'(lim_p), 48'(PCT_FULL));
  wire [47:0] clim_w = orc_div(48'(RATED_CURRENT) * 48'(cfg_q.stall),
                               48'(PCT_FULL));

  assign ramp_limit  = rlim_w[15:0];
  assign const_limit = clim_w[15:0];

  wire ramp_stall  = shortest & (motor_current >= ramp_limit);
  wire const_stall = (state_q == ST_RUN) & ~ramping &
                     (motor_current >= const_limit);

  logic [23:0] step;
  always_comb begin
    case (cfg_q.pattern)
      PAT_S_A: step = step_a;
      PAT_S_B: step = step_b;
      default: step = lin_q;
    endcase
    if (shortest) begin
      step = ramp_stall ? 24'h0 : {step[21:0], 2'b00};
    end
  end

  wire [23:0] up_fp = (tgt_fp - acc_q < step) ? tgt_fp : acc_q + step;
  wire [23:0] dn_fp = (acc_q - tgt_fp < step) ? tgt_fp : acc_q - step;
  wire [23:0] ramp_fp = accel ? up_fp : dn_fp;

  // ==========================================================
  // sequencer
  wire hold_en  = cfg_q.hold_time != CODE_OFF;
  wire rev_req  = reverse_cmd != dir_q;
  wire at_floor = acc_q <= start_fp;

  always_comb begin
    state_d = state_q;
    acc_d   = acc_q;
    dir_d   = dir_q;
    hold_d  = hold_q;
    case (state_q)
      ST_IDLE: begin
        acc_d = 24'h0;
        if (start_cmd && start_ok) begin
          acc_d   = start_fp;
          dir_d   = reverse_cmd;
          hold_d  = 16'(cfg_q.hold_time * 16'(TICKS_PER_CS));
          state_d = hold_en ? ST_HOLD : ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!start_cmd) begin
          state_d = ST_DECEL;
        end else if (rev_req) begin
          state_d = ST_REV;
        end else if (hold_q == 16'h0) begin
          state_d = ST_RUN;
        end else if (tick) begin
          hold_d = hold_q - 16'h1;
        end
      end
      ST_RUN: begin
        if (!start_cmd || !start_ok) begin
          state_d = ST_DECEL;
        end else if (rev_req) begin
          state_d = ST_REV;
        end else if (tick) begin
          acc_d = ramp_fp;
        end
      end
      ST_DECEL: begin
        if (start_cmd && start_ok && !rev_req) begin
          state_d = ST_RUN;
        end else if (tick) begin
          acc_d = ramp_fp;
          if (at_floor) begin
            acc_d   = 24'h0;
            state_d = ST_IDLE;
          end
        end
      end
      ST_REV: begin
        if (!start_cmd) begin
          state_d = ST_DECEL;
        end else if (tick) begin
          acc_d = ramp_fp;
          if (at_floor) begin
            acc_d   = start_fp;
            dir_d   = reverse_cmd;
            state_d = ST_RUN;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        acc_d   = 24'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      acc_q   <= 24'h0;
      dir_q   <= 1'b0;
      hold_q  <= 16'h0;
    end else if (ce) begin
      state_q <= state_d;
      acc_q   <= acc_d;
      dir_q   <= dir_d;
      hold_q  <= hold_d;
    end
  end

  // rate and origin latched only when a new ramp begins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q  <= 2'h0;
      lin_q    <= 24'h1;
      origin_q <= 16'h0;
    end else if (ce && tick) begin
      phase_q <= phase_d;
      if (phase_d != phase_q && phase_d != 2'h0) begin
        lin_q    <= (lin_now == 24'h0) ? 24'h1 : lin_now;
        origin_q <= out_f;
      end
    end
  end

  // ==========================================================
  // outputs
  assign stat = '{shortest, ramp_stall | const_stall,
                  state_q == ST_HOLD, state_q != ST_IDLE, state_q,
                  dir_q, out_f};

  assign freq_out     = out_f;
  assign dir_out      = dir_q;
  assign running      = state_q != ST_IDLE;
  assign holding      = state_q == ST_HOLD;
  assign stall_active = ramp_stall | const_stall;

endmodule : orc_ramp_control

// ### bench/orc_checker.sv
// port checker for the ramp control
`timescale 1ns/1ns
module orc_checker
  import orc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        start_cmd,
  input wire logic [15:0] freq_out,
  input wire logic        running,
  input wire logic        holding,
  input wire logic        stall_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  ready_is_ce_a: assert property (pready == ce)
    else $error("pready differs from ce");
  err_access_a: assert property (!penable |-> !pslverr)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h48
    |-> pslverr) else $error("no pslverr on unmapped");
  start_cause_a: assert property ($rose(running) |-> $past(start_cmd))
    else $error("run without start");
  idle_zero_a: assert property (!running |-> freq_out == 16'h0000)
    else $error("output while idle");
  hold_run_a: assert property (holding |-> running)
    else $error("hold while idle");
  hold_release_a: assert property (holding && !start_cmd && ce
    |-> ##[1:2] !holding) else $error("hold kept after release");
  tick_step_a: assert property (!$stable(freq_out) && running
    && $past(running) |=> ($stable(freq_out) || !running)[*8])
    else $error("steps too close");
  freeze_a: assert property (!ce |=> $stable(freq_out) && $stable(holding))
    else $error("moved while ce low");
  stall_run_a: assert property (stall_active |-> running)
    else $error("stall while idle");
  // ==========
  // covers
  hold_c: cover property ($rose(holding));
  err_c: cover property (pslverr);
  stall_c: cover property ($rose(stall_active));
endmodule : orc_checker
bind orc_ramp_control orc_checker u_chk (.clk_sys, .rst_n, .ce, .paddr,
  .psel, .penable, .pready, .pslverr, .start_cmd, .freq_out, .running,
  .holding, .stall_active);

// ### bench/orc_motor_model.sv
// motor current model driven by the output frequency
`timescale 1ns/1ns
module orc_motor_model
  import orc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic [15:0] freq_out,
  input wire logic        overload,
  output logic     [15:0] motor_current
);
  always_ff @(posedge clk_sys) begin
    motor_current <= overload ? 16'h0FA0 : {8'h00, freq_out[15:8]};
  end
endmodule : orc_motor_model

// ### bench/orc_ramp_control_tb.sv
// self-checking bench for the ramp control
`timescale 1ns/1ns
module orc_ramp_control_tb;
  import orc_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, overload = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start_cmd = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] freq_cmd = 16'h0010, motor_current, freq_out;
  logic        pready, pslverr, err, dir_out, running, holding, stall_active;
  logic        reverse_cmd = 1'b0, second_function_select = 1'b0;
  int          miscompares = 0, num_checks = 0, cyc = 0, n;
  orc_ramp_control #(.TICK_LEN(20)) dut (.clk_sys, .rst_n, .ce, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .start_cmd, .reverse_cmd, .second_function_select, .freq_cmd,
    .motor_current, .freq_out, .dir_out, .running, .holding, .stall_active);
  orc_motor_model u_motor (.clk_sys, .freq_out, .overload, .motor_current);
  always #25 clk_sys = ~clk_sys;
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cyc_wait(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc_wait
  task automatic wait_freq(input logic [15:0] f);
    n = 0;
    while (freq_out !== f && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n > 1500 && n < 1700, 1);
  endtask : wait_freq
  task automatic t_regs;
    logic [15:0] c[5] = '{16'h1, 16'h7, 16'h8, 16'hB, 16'h0};
    apb(0, OFS_START_FREQ, 0);
    chk(rd, 32'h32);
    apb(0, OFS_REF_CUR, 0);
    chk(rd, 32'h270F);
    apb(0, OFS_LIMITS, 0);
    chk(rd, 32'h0078_0078);
    apb(1, OFS_RAMP_REF, 32'hBB8);
    apb(0, OFS_GAIN, 0);
    chk(rd, 32'h1770);
    apb(1, OFS_START_FREQ, 32'h1771);
    chk(err, 1);
    for (int i = 3; i >= 0; i--) begin
      apb(1, OFS_PATTERN, i);
      chk(err, i == 3);
    end
    foreach (c[i]) begin
      apb(1, OFS_AUTO, c[i]);
      chk(err, 0);
    end
    apb(0, 8'h80, 0);
    chk(rd, 0);
    chk(err, 1);
    $display("regs done");
  endtask : t_regs
  task automatic t_refuse;
    start_cmd <= 1'b1;
    cyc_wait(60);
    chk(running, 0);
    apb(1, OFS_MIN_FREQ, 32'h32);
    cyc_wait(3);
    chk({running, freq_out}, 32'h10032);
    start_cmd <= 1'b0;
    cyc_wait(60);
    chk(running, 0);
    apb(1, OFS_MIN_FREQ, 0);
    $display("refuse done");
  endtask : t_refuse
  task automatic t_hold;
    apb(1, OFS_HOLD_TIME, 1);
    freq_cmd <= 16'h2710;
    start_cmd <= 1'b1;
    cyc_wait(3);
    chk({holding, freq_out}, 32'h10032);
    ce <= 1'b0;
    cyc_wait(300);
    ce <= 1'b1;
    cyc_wait(100);
    chk({holding, freq_out}, 32'h10032);
    start_cmd <= 1'b0;
    cyc_wait(3);
    chk(holding, 0);
    cyc_wait(60);
    $display("hold done");
  endtask : t_hold
  task automatic t_ramp;
    apb(1, OFS_HOLD_TIME, 32'h270F);
    apb(1, OFS_ACCEL, 3);
    apb(1, OFS_DECEL, 3);
    start_cmd <= 1'b1;
    wait_freq(16'h1770);
    overload <= 1'b1;
    cyc_wait(3);
    chk(stall_active, 1);
    overload <= 1'b0;
    start_cmd <= 1'b0;
    wait_freq(16'h0000);
    $display("ramp done");
  endtask : t_ramp
  task automatic t_rev;
    cyc_wait(30);
    apb(1, OFS_ACCEL, 32'h1F4);
    apb(1, OFS_ACCEL2, 3);
    second_function_select <= 1'b1;
    start_cmd <= 1'b1;
    wait_freq(16'h1770);
    apb(1, OFS_HOLD_TIME, 1);
    reverse_cmd <= 1'b1;
    wait_freq(16'h0032);
    chk({dir_out, running, holding}, 6);
    $display("rev done");
  endtask : t_rev
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ==========
  // main
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    cyc_wait(12);
    rst_n <= 1'b1;
    t_regs;
    t_refuse;
    t_hold;
    t_ramp;
    t_rev;
    report_and_stop;
  end
endmodule : orc_ramp_control_tb
